// ===== logic/ssp_port.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_port #(
    parameter int ADDR_W = ssp_pkg::ADDR_W_DEF,
    parameter int WORD_W = ssp_pkg::WORD_WIDE
) (
    // System clock for the array and write engine
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Input strobe pair
    input wire logic strobe_clk,
    input wire logic strobe_clk_n,
    // Output timing pair
    input wire logic out_clk,
    input wire logic out_clk_n,
    input wire logic out_clk_present,
    // Static mode pin
    input wire logic pll_bypass_pin,
    // Address and write data
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] write_data,
    // Read data, one register per launch edge
    output logic [WORD_W-1:0] read_data_rise,
    output logic [WORD_W-1:0] read_data_fall,
    output logic read_valid_rise,
    output logic read_valid_fall,
    // Echo clocks, one toggle per launch edge
    output logic echo_clock_rise,
    output logic echo_clock_fall
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CMD_W = ADDR_W + ssp_pkg::BURST_LEN * WORD_W;

    generate
        if (WORD_W != ssp_pkg::WORD_NARROW && WORD_W != ssp_pkg::WORD_WIDE) begin : g_bad_word
            $error("ssp_port: WORD_W must be 8 or 18");
        end
        if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
            $error("ssp_port: ADDR_W out of range");
        end
    endgenerate

    // Strobe domain
    logic k_rst;
    ssp_pkg::ssp_phase_e phase;
    ssp_pkg::ssp_phase_e next_phase;
    logic [ADDR_W-1:0] rd_addr_k;
    logic [ADDR_W-1:0] next_rd_addr_k;
    logic [ADDR_W-1:0] wr_addr_k;
    logic [ADDR_W-1:0] next_wr_addr_k;
    logic [CMD_W-1:0] wr_cmd_k;
    logic [CMD_W-1:0] next_wr_cmd_k;
    logic rd_tgl;
    logic next_rd_tgl;
    logic wr_tgl;
    logic next_wr_tgl;
    logic rd_slot;
    logic next_rd_slot;
    logic rd_go;
    logic next_rd_go;
    logic wr_due;
    logic next_wr_due;
    logic [WORD_W-1:0] beat0_kn;

    ssp_sync2 #(.W(1)) u_sync_k (
        .clk(strobe_clk),
        .d(sys_rst),
        .q(k_rst)
    );

    always_comb begin
        next_phase = (phase == ssp_pkg::PH_READ) ? ssp_pkg::PH_WRITE : ssp_pkg::PH_READ;
        next_rd_addr_k = rd_addr_k;
        next_wr_addr_k = wr_addr_k;
        next_wr_cmd_k = wr_cmd_k;
        next_rd_tgl = rd_tgl;
        next_wr_tgl = wr_tgl;
        next_rd_slot = 1'b0;
        next_wr_due = 1'b0;
        // Read slot delayed by one strobe cycle for a lagging output timing pair
        next_rd_go = rd_slot;
        case (phase)
            ssp_pkg::PH_READ: begin
                next_rd_addr_k = addr;
                next_rd_tgl = ~rd_tgl;
                next_rd_slot = 1'b1;
            end
            ssp_pkg::PH_WRITE: begin
                next_wr_addr_k = addr;
                next_wr_due = 1'b1;
            end
            default: begin
                next_rd_slot = 1'b0;
            end
        endcase
        // Second beat arrives on the edge after the write address
        if (wr_due) begin
            next_wr_cmd_k = {wr_addr_k, beat0_kn, write_data};
            next_wr_tgl = ~wr_tgl;
        end
        if (k_rst) begin
            next_phase = ssp_pkg::PH_READ;
            next_rd_tgl = ssp_pkg::RST_TGL;
            next_wr_tgl = ssp_pkg::RST_TGL;
            next_rd_slot = ssp_pkg::RST_FLAG;
            next_wr_due = ssp_pkg::RST_FLAG;
            next_rd_go = ssp_pkg::RST_FLAG;
        end
    end

    always_ff @(posedge strobe_clk) begin
        phase <= next_phase;
        rd_addr_k <= next_rd_addr_k;
        wr_addr_k <= next_wr_addr_k;
        wr_cmd_k <= next_wr_cmd_k;
        rd_tgl <= next_rd_tgl;
        wr_tgl <= next_wr_tgl;
        rd_slot <= next_rd_slot;
        wr_due <= next_wr_due;
        rd_go <= next_rd_go;
    end

    // Inverted partner supplies the half-cycle capture edge
    always_ff @(posedge strobe_clk_n) begin
        beat0_kn <= write_data;
    end

    // System domain: array and self-timed write engine
    logic [1:0] s_tgl;
    logic [1:0] s_tgl_d;
    logic rd_evt;
    logic wr_evt;
    logic wr_pend;
    logic next_wr_pend;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [CMD_W-1:0] buf_out_data;
    logic wr_take;
    logic [ADDR_W-1:0] wr_addr_s;
    logic [WORD_W-1:0] rd_w0;
    logic [WORD_W-1:0] rd_w1;
    logic [WORD_W-1:0] next_rd_w0;
    logic [WORD_W-1:0] next_rd_w1;
    logic [WORD_W-1:0] mem0 [DEPTH];
    logic [WORD_W-1:0] mem1 [DEPTH];

    ssp_sync2 #(.W(2)) u_sync_s (
        .clk(sys_clk),
        .d({rd_tgl, wr_tgl}),
        .q(s_tgl)
    );

    assign rd_evt = s_tgl[1] ^ s_tgl_d[1];
    assign wr_evt = s_tgl[0] ^ s_tgl_d[0];
    // Reads own the array port; the buffer absorbs the stalled write
    assign wr_take = buf_out_valid && !rd_evt;
    assign wr_addr_s = buf_out_data[CMD_W-1 -: ADDR_W];

    ssp_buf2 #(.W(CMD_W)) u_wbuf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(wr_pend || wr_evt),
        .in_ready(buf_in_ready),
        .in_data(wr_cmd_k),
        .out_valid(buf_out_valid),
        .out_ready(!rd_evt),
        .out_data(buf_out_data)
    );

    always_comb begin
        next_wr_pend = (wr_pend || wr_evt) && !buf_in_ready;
        next_rd_w0 = rd_w0;
        next_rd_w1 = rd_w1;
        if (rd_evt) begin
            next_rd_w0 = mem0[rd_addr_k];
            next_rd_w1 = mem1[rd_addr_k];
        end
        if (sys_rst) begin
            next_wr_pend = ssp_pkg::RST_FLAG;
        end
    end

    always_ff @(posedge sys_clk) begin
        s_tgl_d <= sys_rst ? 2'h0 : s_tgl;
        wr_pend <= next_wr_pend;
        rd_w0 <= next_rd_w0;
        rd_w1 <= next_rd_w1;
        if (wr_take) begin
            mem0[wr_addr_s] <= buf_out_data[2*WORD_W-1 -: WORD_W];
            mem1[wr_addr_s] <= buf_out_data[WORD_W-1:0];
        end
    end

    // Launch domains: output timing pair if present, else strobe pair
    logic lr_clk;
    logic lf_clk;
    logic [2:0] lr_s;
    logic [1:0] lf_s;
    logic lr_req;
    logic lr_hit;
    logic next_lr_hit;
    logic lf_hit;
    logic next_lf_hit;
    logic [WORD_W-1:0] next_data_rise;
    logic [WORD_W-1:0] next_data_fall;
    logic next_valid_rise;
    logic next_valid_fall;

    assign lr_clk = out_clk_present ? out_clk : strobe_clk;
    assign lf_clk = out_clk_present ? out_clk_n : strobe_clk_n;

    ssp_sync2 #(.W(3)) u_sync_lr (
        .clk(lr_clk),
        .d({out_clk_present, sys_rst, pll_bypass_pin}),
        .q(lr_s)
    );

    // Strobe launch sees the slot at the next strobe edge; a pair that lags the
    // strobe by under half a cycle sees it one edge early, so it takes the delayed slot
    assign lr_req = lr_s[2] ? rd_go : rd_slot;

    ssp_sync2 #(.W(2)) u_sync_lf (
        .clk(lf_clk),
        .d({sys_rst, pll_bypass_pin}),
        .q(lf_s)
    );

    always_comb begin
        next_lr_hit = lr_req && !lr_s[1];
        next_valid_rise = 1'b0;
        next_data_rise = read_data_rise;
        if (lr_s[0] != ssp_pkg::BYPASS_LONG && lr_req) begin
            next_valid_rise = 1'b1;
            next_data_rise = rd_w0;
        end else if (lr_s[0] == ssp_pkg::BYPASS_LONG && lf_hit) begin
            next_valid_rise = 1'b1;
            next_data_rise = rd_w1;
        end
        if (lr_s[1]) begin
            next_valid_rise = ssp_pkg::RST_FLAG;
        end
    end

    always_ff @(posedge lr_clk) begin
        lr_hit <= next_lr_hit;
        read_valid_rise <= next_valid_rise;
        read_data_rise <= next_data_rise;
        echo_clock_rise <= lr_s[1] ? ssp_pkg::RST_FLAG : ~echo_clock_rise;
    end

    always_comb begin
        next_lf_hit = lr_hit && (lf_s[0] == ssp_pkg::BYPASS_LONG) && !lf_s[1];
        next_valid_fall = lr_hit && !lf_s[1];
        next_data_fall = read_data_fall;
        if (lr_hit) begin
            next_data_fall = (lf_s[0] == ssp_pkg::BYPASS_LONG) ? rd_w0 : rd_w1;
        end
    end

    always_ff @(posedge lf_clk) begin
        lf_hit <= next_lf_hit;
        read_valid_fall <= next_valid_fall;
        read_data_fall <= next_data_fall;
        echo_clock_fall <= lf_s[1] ? ssp_pkg::RST_FLAG : ~echo_clock_fall;
    end

    // Checks
    a_phase_alternates: assert property (@(posedge strobe_clk) disable iff (k_rst)
        phase == ssp_pkg::PH_READ |=> phase == ssp_pkg::PH_WRITE ##1 phase == ssp_pkg::PH_READ)
        else $error("address phase did not alternate");

    a_read_addr_toggle: assert property (@(posedge strobe_clk) disable iff (k_rst)
        phase == ssp_pkg::PH_READ |=> rd_tgl != $past(rd_tgl) && rd_addr_k == $past(addr))
        else $error("read address not latched on read phase");

    a_write_cmd_beats: assert property (@(posedge strobe_clk) disable iff (k_rst)
        wr_due |=> wr_cmd_k[WORD_W-1:0] == $past(write_data) && wr_tgl != $past(wr_tgl))
        else $error("write burst not captured");

    a_read_priority: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_evt |-> !wr_take)
        else $error("write took the array during a read");

    a_read_words: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_evt |=> rd_w0 == $past(mem0[rd_addr_k]) && rd_w1 == $past(mem1[rd_addr_k]))
        else $error("read words not fetched");

    a_write_commit: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_take |=> mem0[$past(wr_addr_s)] == $past(buf_out_data[2*WORD_W-1 -: WORD_W]))
        else $error("first word not written");

    a_pend_bounded: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_pend |-> ##[0:8] !wr_pend)
        else $error("write stuck in front of the buffer");

    a_short_launch: assert property (@(posedge lr_clk) disable iff (lr_s[1])
        (lr_s[0] != ssp_pkg::BYPASS_LONG && lr_req) |=> read_valid_rise && read_data_rise == $past(rd_w0))
        else $error("short latency read missed its edge");

    a_long_launch: assert property (@(posedge lf_clk) disable iff (lf_s[1])
        (lf_s[0] == ssp_pkg::BYPASS_LONG && lr_hit) |=> read_valid_fall && read_data_fall == $past(rd_w0))
        else $error("long latency read missed its edge");

    c_read_seen: cover property (@(posedge sys_clk) disable iff (sys_rst) rd_evt);
    c_write_stall: cover property (@(posedge sys_clk) disable iff (sys_rst) buf_out_valid && rd_evt);
    c_long_mode: cover property (@(posedge lr_clk) disable iff (lr_s[1]) read_valid_rise && lr_s[0]);
endmodule
`default_nettype wire

// ===== logic/ssp_pkg.sv
package ssp_pkg;
    // Word widths of the two variants
    localparam int WORD_NARROW = 8;
    localparam int WORD_WIDE = 18;
    // Words per address location
    localparam int BURST_LEN = 2;
    // Default address width of the wide variant
    localparam int ADDR_W_DEF = 20;
    // Buffer depth in the write path
    localparam int WBUF_DEPTH = 2;
    // Synchroniser length and reset values
    localparam int SYNC_STAGES = 2;
    localparam logic RST_TGL = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    // Bypass pin level that selects the extra half cycle of read latency
    localparam logic BYPASS_LONG = 1'b1;

    // Which kind of address the next strobe rising edge latches
    typedef enum logic {
        PH_READ = 1'b0,
        PH_WRITE = 1'b1
    } ssp_phase_e;
endpackage

// ===== logic/ssp_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_sync2 #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Level from another domain or a pin
    input wire logic [W-1:0] d,
    // Synchronised level
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    generate
        if (W < 1) begin : g_bad_w
            $error("ssp_sync2: W must be at least 1");
        end
    endgenerate

    // First stage feeds the second stage only
    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        q <= next_q;
    end
endmodule
`default_nettype wire

// ===== logic/ssp_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_buf2 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0] count;
    logic [W-1:0] next_d0;
    logic [W-1:0] next_d1;
    logic [1:0] next_count;
    logic push;
    logic pop;
    logic [1:0] slot;

    generate
        if (W < 1) begin : g_bad_w
            $error("ssp_buf2: W must be at least 1");
        end
    endgenerate

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = d0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_d0 = d0;
        next_d1 = d1;
        slot = count - {1'b0, pop};
        if (pop) begin
            next_d0 = d1;
        end
        if (push) begin
            if (slot == 2'h0) begin
                next_d0 = in_data;
            end else begin
                next_d1 = in_data;
            end
        end
        next_count = count + {1'b0, push} - {1'b0, pop};
        if (sys_rst) begin
            next_count = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        d0 <= next_d0;
        d1 <= next_d1;
        count <= next_count;
    end
endmodule
`default_nettype wire

// ===== sim/ssp_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_ctrl_model #(
    parameter int ADDR_W = 8,
    parameter int WORD_W = 18,
    parameter realtime HALF = 62.5,
    parameter realtime OUT_SKEW = 10.0
) (
    // Reset as the controller sees it
    input wire logic sys_rst,
    // Input strobe pair
    output logic strobe_clk,
    output logic strobe_clk_n,
    // Output timing pair
    output logic out_clk,
    output logic out_clk_n,
    // Address and write data
    output logic [ADDR_W-1:0] addr,
    output logic [WORD_W-1:0] write_data
);
    localparam logic [ADDR_W-1:0] PARK = '1;
    int n = 0;

    // Offset off the system clock grid so no edge is ever shared
    initial begin
        strobe_clk = 1'b0;
        out_clk = 1'b0;
        addr = PARK;
        write_data = '0;
        #1.3;
        forever #(HALF) strobe_clk = ~strobe_clk;
    end
    assign strobe_clk_n = ~strobe_clk;
    assign out_clk_n = ~out_clk;

    always @(strobe_clk) begin
        out_clk <= #(OUT_SKEW) strobe_clk;
    end

    // Strobe rises since reset was seen low; odd counts from 3 on are read edges
    always @(posedge strobe_clk) begin
        if (sys_rst) begin
            n <= 0;
        end else begin
            n <= n + 1;
        end
    end

    // One read and one write; returns the count at the read edge
    task automatic slot(input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa,
            input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1, output int r);
        while (n < 2 || n[0]) begin
            @(posedge strobe_clk);
            #1;
        end
        addr = ra;
        @(posedge strobe_clk);
        #1;
        r = n;
        addr = wa;
        @(posedge strobe_clk);
        #1;
        // Idle cycles park on one address so stray writes hurt nothing under test
        addr = PARK;
        // Beat 0 on the half-cycle edge after the write address, beat 1 on the next read edge
        write_data = w0;
        @(posedge strobe_clk_n);
        #1;
        write_data = w1;
    endtask
endmodule
`default_nettype wire

// ===== sim/separate_io_burst2_sram_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module separate_io_burst2_sram_port_tb;
    localparam int AW = 8;
    localparam int WW = ssp_pkg::WORD_WIDE;
    localparam int LIMIT = 20000;
    localparam logic [AW-1:0] PARK = '1;
    localparam logic [AW-1:0] ADDRS [4] = '{8'h00, 8'h01, 8'h5a, 8'hfe};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic strobe_clk, strobe_clk_n, out_clk, out_clk_n;
    logic out_clk_present = 1'b1;
    logic pll_bypass_pin = 1'b0;
    logic [AW-1:0] addr;
    logic [WW-1:0] write_data, read_data_rise, read_data_fall;
    logic read_valid_rise, read_valid_fall, echo_clock_rise, echo_clock_fall;
    logic rclk, fclk;
    logic echo_on = 1'b0;
    logic last_er = 1'b0;
    logic last_ef = 1'b0;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int o_hc[$];
    logic [WW-1:0] o_d[$];
    int e_hc[$];
    logic [WW-1:0] e_d[$];
    bit e_care[$];
    logic [WW-1:0] m0 [256];
    logic [WW-1:0] m1 [256];

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    ssp_port #(.ADDR_W(AW), .WORD_W(WW)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .strobe_clk(strobe_clk), .strobe_clk_n(strobe_clk_n), .out_clk(out_clk),
        .out_clk_n(out_clk_n), .out_clk_present(out_clk_present),
        .pll_bypass_pin(pll_bypass_pin), .addr(addr), .write_data(write_data),
        .read_data_rise(read_data_rise), .read_data_fall(read_data_fall),
        .read_valid_rise(read_valid_rise), .read_valid_fall(read_valid_fall),
        .echo_clock_rise(echo_clock_rise), .echo_clock_fall(echo_clock_fall));

    ssp_ctrl_model #(.ADDR_W(AW), .WORD_W(WW)) ctrl (.sys_rst(sys_rst),
        .strobe_clk(strobe_clk), .strobe_clk_n(strobe_clk_n), .out_clk(out_clk),
        .out_clk_n(out_clk_n), .addr(addr), .write_data(write_data));

    assign rclk = out_clk_present ? out_clk : strobe_clk;
    assign fclk = out_clk_present ? out_clk_n : strobe_clk_n;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Beats are logged in strobe half cycles so latency is checked to the half
    always @(posedge rclk) begin
        #2;
        if (read_valid_rise === 1'b1) begin
            o_hc.push_back(2 * ctrl.n);
            o_d.push_back(read_data_rise);
        end
        if (echo_on) check("echo_rise", {31'h0, echo_clock_rise}, {31'h0, ~last_er});
        last_er = echo_clock_rise;
    end

    always @(posedge fclk) begin
        #2;
        if (read_valid_fall === 1'b1) begin
            o_hc.push_back(2 * ctrl.n + 1);
            o_d.push_back(read_data_fall);
        end
        if (echo_on) check("echo_fall", {31'h0, echo_clock_fall}, {31'h0, ~last_ef});
        last_ef = echo_clock_fall;
    end

    task automatic cyc(input logic [AW-1:0] ra, input logic [AW-1:0] wa,
            input logic [WW-1:0] w0, input logic [WW-1:0] w1,
            input logic [WW-1:0] x0, input logic [WW-1:0] x1, input bit care);
        int r;
        int h;
        ctrl.slot(ra, wa, w0, w1, r);
        h = (pll_bypass_pin === ssp_pkg::BYPASS_LONG) ? 2 * r + 3 : 2 * r + 2;
        e_hc.push_back(h);
        e_d.push_back(x0);
        e_care.push_back(care);
        e_hc.push_back(h + 1);
        e_d.push_back(x1);
        e_care.push_back(care);
    endtask

    task automatic judge();
        int i;
        cyc(PARK, PARK, '0, '0, '0, '0, 1'b0);
        cyc(PARK, PARK, '0, '0, '0, '0, 1'b0);
        repeat (3) @(posedge strobe_clk);
        #20;
        // Beats from idle cycles before the scenario are dropped
        while (o_hc.size() > 0 && o_hc[0] < e_hc[0]) begin
            o_hc.pop_front();
            o_d.pop_front();
        end
        check("beat_count", 32'(o_hc.size() >= e_hc.size()), 32'h1);
        for (i = 0; i < e_hc.size() && i < o_hc.size(); i++) begin
            check("beat_time", o_hc[i], e_hc[i]);
            if (e_care[i]) check("beat_data", o_d[i], e_d[i]);
        end
        o_hc.delete();
        o_d.delete();
        e_hc.delete();
        e_d.delete();
        e_care.delete();
    endtask

    task automatic do_reset(input bit long_lat, input bit use_oc);
        @(negedge sys_clk);
        echo_on = 1'b0;
        sys_rst = 1'b1;
        // Mode pins change only under reset
        pll_bypass_pin = long_lat ? ssp_pkg::BYPASS_LONG : ~ssp_pkg::BYPASS_LONG;
        out_clk_present = use_oc;
        // Longer than usual: every link domain needs three edges of reset
        repeat (64) @(negedge sys_clk);
        sys_rst = 1'b0;
        while (ctrl.n < 4) @(negedge sys_clk);
        echo_on = 1'b1;
    endtask

    // Fill, overwrite while reading the same place, then read back to back
    task automatic s_traffic(input bit long_lat, input bit use_oc, input int k);
        logic [WW-1:0] v0;
        logic [WW-1:0] v1;
        int i;
        int p;
        do_reset(long_lat, use_oc);
        o_hc.delete();
        o_d.delete();
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 4; i++) begin
                v0 = WW'(32'h15000 + k * 32'h1000 + p * 32'h400 + ADDRS[i] * 2);
                v1 = v0 ^ WW'(32'h1);
                if (p == 0) begin
                    cyc(PARK, ADDRS[i], v0, v1, '0, '0, 1'b0);
                end else begin
                    cyc(ADDRS[i], ADDRS[i], v0, v1, m0[ADDRS[i]], m1[ADDRS[i]], 1'b1);
                end
                m0[ADDRS[i]] = v0;
                m1[ADDRS[i]] = v1;
            end
        end
        for (i = 0; i < 4; i++) begin
            cyc(ADDRS[i], PARK, '0, '0, m0[ADDRS[i]], m1[ADDRS[i]], 1'b1);
        end
        judge();
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("BAD timeout expected %0d seen %0d", LIMIT - 1, cycles);
            tally_and_finish();
        end
    end

    initial begin
        s_traffic(1'b0, 1'b1, 0);
        s_traffic(1'b1, 1'b1, 1);
        s_traffic(1'b0, 1'b0, 2);
        s_traffic(1'b1, 1'b0, 3);
        tally_and_finish();
    end
endmodule
`default_nettype wire
